// ==== pkg/ccrc_pkg.sv ====
// Shared types, reset values and timing counts for the card clock and reset control
package ccrc_pkg;

    // Link clock runs at twice the host bus rate; full card clock toggles every link cycle
    localparam int HALF_FULL   = 1;
    localparam int HALF_SLOW   = 8;
    localparam int CNT_W       = 8;
    localparam int ANN_EDGES   = 4;
    localparam int ANN_W       = 3;

    typedef enum logic [1:0] {
        CCRC_RUN,
        CCRC_ANNOUNCE,
        CCRC_SLOW,
        CCRC_STOP
    } ccrc_state_t;

    typedef struct packed {
        logic slow;
        logic stop;
        logic card_rst;
    } ccrc_cmd_t;

    typedef struct packed {
        logic slow;
        logic stop;
        logic card_in_rst;
    } ccrc_stat_t;

    typedef struct packed {
        ccrc_cmd_t  cmd;
        ccrc_stat_t stat_s1;
        ccrc_stat_t stat_s2;
    } ccrc_host_t;

    typedef struct packed {
        ccrc_state_t            st;
        logic [CNT_W-1:0]       div_cnt;
        logic [ANN_W-1:0]       ann_cnt;
        logic                   cclk;
        logic                   stb;
        logic                   clkrun_o;
        logic                   clkrun_oe;
        logic                   park_oe;
        logic [1:0]             clkrun_sync;
        ccrc_cmd_t              cmd_s1;
        ccrc_cmd_t              cmd_s2;
        ccrc_stat_t             stat;
    } ccrc_link_t;

    localparam ccrc_cmd_t  CMD_RST  = '{slow: 1'h0, stop: 1'h0, card_rst: 1'h1};
    localparam ccrc_stat_t STAT_RST = '{slow: 1'h0, stop: 1'h0, card_in_rst: 1'h1};
    localparam ccrc_host_t HOST_RST = '{cmd: CMD_RST, stat_s1: STAT_RST, stat_s2: STAT_RST};
    localparam ccrc_link_t LINK_RST = '{
        st:          CCRC_RUN,
        div_cnt:     '0,
        ann_cnt:     '0,
        cclk:        1'h0,
        stb:         1'h0,
        clkrun_o:    1'h0,
        clkrun_oe:   1'h1,
        park_oe:     1'h1,
        clkrun_sync: 2'h3,
        cmd_s1:      CMD_RST,
        cmd_s2:      CMD_RST,
        stat:        STAT_RST
    };

endpackage : ccrc_pkg

// ==== verilog/ccrc_rst_sync.sv ====
// Reset stage with asynchronous assertion and release stepped by an advance strobe
`timescale 1ns/1ps
module ccrc_rst_sync (
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    input  wire logic adv_in,
    output logic      rst_n_out
);

    typedef struct packed {
        logic s0;
        logic s1;
    } ccrc_rs_t;

    ccrc_rs_t r_q;
    ccrc_rs_t r_d;

    // First stage feeds only the second, so a late release cannot go metastable downstream
    always_comb
    begin
        r_d = r_q;
        if (adv_in)
        begin
            r_d.s0 = 1'h1;
            r_d.s1 = r_q.s0;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign rst_n_out = r_q.s1;

endmodule : ccrc_rst_sync

// ==== verilog/ccrc_clock_reset_ctrl.sv ====
// Card clock, clock-run and card reset control for the bridge socket
// Function
// [RULE1] Card signals sampled on rising card clock
// [RULE2] Full card clock equals host bus rate
// [RULE3] Card clock may slow; stops only low
// [RULE4] Card requests faster clock on clock-run
// [RULE5] Bridge announces slowdown on clock-run first
// [RULE6] Card floats its outputs during reset
// [RULE7] Bridge parks interface lines during reset
// [RULE8] Card returns to initial state on reset
// [RULE9] Reset asserts anytime, releases on card clock
// [RULE10] Full clock kept while card request pending
`timescale 1ns/1ps
module ccrc_clock_reset_ctrl #(
    parameter int HALF_SLOW = ccrc_pkg::HALF_SLOW,
    parameter int ANN_EDGES = ccrc_pkg::ANN_EDGES
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic link_clk_in,
    input  wire logic slow_req_in,
    input  wire logic stop_req_in,
    input  wire logic card_rst_req_in,
    input  wire logic clkrun_in,
    output logic      cclk_out,
    output logic      clkrun_out,
    output logic      clkrun_oe_out,
    output logic      crst_n_out,
    output logic      park_oe_out,
    output logic      sample_stb_out,
    output logic      slow_out,
    output logic      stopped_out,
    output logic      card_in_rst_out
);

    localparam int CW = ccrc_pkg::CNT_W;
    localparam int AW = ccrc_pkg::ANN_W;
    localparam logic [AW-1:0] ANN_LAST = AW'(ANN_EDGES - 1);

    if (HALF_SLOW <= ccrc_pkg::HALF_FULL || HALF_SLOW > (1 << CW))
    begin : g_bad_slow
        $error("HALF_SLOW out of range");
    end
    // Fewer edges end the announcement before the released pin has crossed the synchroniser
    if (ANN_EDGES < 3 || ANN_EDGES > (1 << AW))
    begin : g_bad_ann
        $error("ANN_EDGES out of range");
    end

    ccrc_pkg::ccrc_host_t h_q;
    ccrc_pkg::ccrc_host_t h_d;
    ccrc_pkg::ccrc_link_t l_q;
    ccrc_pkg::ccrc_link_t l_d;
    logic                 lrst_n;
    logic                 rise;
    logic                 card_arst_n;

    function automatic logic [CW-1:0] half_for(input ccrc_pkg::ccrc_state_t st);
        half_for = (st == ccrc_pkg::CCRC_SLOW) ? CW'(HALF_SLOW) : CW'(ccrc_pkg::HALF_FULL);
    endfunction : half_for

    // Host side: commands come from same-clock logic, status returns through two flops
    always_comb
    begin
        h_d              = h_q;
        h_d.cmd.slow     = slow_req_in;
        h_d.cmd.stop     = stop_req_in;
        h_d.cmd.card_rst = card_rst_req_in;
        h_d.stat_s1      = l_q.stat;
        h_d.stat_s2      = h_q.stat_s1;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            h_q <= ccrc_pkg::HOST_RST;
        else
            h_q <= h_d;
    end

    ccrc_rst_sync u_link_rst (
        .clk_in    (link_clk_in),
        .arst_n_in (rst_n_in),
        .adv_in    (1'h1),
        .rst_n_out (lrst_n)
    );

    // Card reset drops at once; its release waits for a rising card clock edge
    assign card_arst_n = lrst_n & ~l_q.cmd_s2.card_rst;

    ccrc_rst_sync u_card_rst (
        .clk_in    (link_clk_in),
        .arst_n_in (card_arst_n),
        .adv_in    (rise), // RULE9
        .rst_n_out (crst_n_out)
    );

    always_comb
    begin
        logic want_slow;
        logic req;
        logic tgl;
        want_slow = 1'h0;
        req       = 1'h0;
        tgl       = 1'h0;
        l_d             = l_q;
        l_d.clkrun_sync = {l_q.clkrun_sync[0], clkrun_in};
        l_d.cmd_s1      = h_q.cmd;
        l_d.cmd_s2      = l_q.cmd_s1;
        want_slow = (l_q.cmd_s2.slow | l_q.cmd_s2.stop) & ~l_q.cmd_s2.card_rst;
        req       = ~l_q.clkrun_sync[1];
        tgl       = (l_q.st != ccrc_pkg::CCRC_STOP) && (l_q.div_cnt >= half_for(l_q.st) - 1'h1);
        l_d.div_cnt = tgl ? '0 : CW'(l_q.div_cnt + 1'h1); // RULE2
        if (l_q.st == ccrc_pkg::CCRC_STOP)
            l_d.div_cnt = l_q.div_cnt;
        l_d.cclk = tgl ? ~l_q.cclk : l_q.cclk; // RULE3
        rise     = tgl & ~l_q.cclk;
        l_d.stb  = rise; // RULE1
        case (l_q.st)
            ccrc_pkg::CCRC_RUN:
            begin
                l_d.clkrun_oe = 1'h1;
                if (want_slow)
                begin
                    l_d.st        = ccrc_pkg::CCRC_ANNOUNCE; // RULE5
                    l_d.ann_cnt   = '0;
                    l_d.clkrun_oe = 1'h0;
                end
            end
            ccrc_pkg::CCRC_ANNOUNCE:
            begin
                if (!want_slow)
                begin
                    l_d.st        = ccrc_pkg::CCRC_RUN;
                    l_d.clkrun_oe = 1'h1;
                end
                else if (l_q.ann_cnt != ANN_LAST)
                begin
                    if (rise)
                        l_d.ann_cnt = AW'(l_q.ann_cnt + 1'h1);
                end
                else if (req)
                begin
                    l_d.st        = ccrc_pkg::CCRC_RUN; // RULE10
                    l_d.clkrun_oe = 1'h1;
                end
                else if (!l_q.cmd_s2.stop)
                    l_d.st = ccrc_pkg::CCRC_SLOW;
                // Stop on the falling toggle so the stopped state never shows a high clock
                else if (l_q.cclk && tgl)
                    l_d.st = ccrc_pkg::CCRC_STOP; // RULE3
            end
            ccrc_pkg::CCRC_SLOW:
            begin
                if (req || !want_slow)
                begin
                    l_d.st        = ccrc_pkg::CCRC_RUN; // RULE4
                    l_d.clkrun_oe = 1'h1;
                end
                else if (l_q.cmd_s2.stop && !l_q.cclk && !tgl)
                    l_d.st = ccrc_pkg::CCRC_STOP;
            end
            ccrc_pkg::CCRC_STOP:
            begin
                l_d.cclk = 1'h0;
                if (req || !want_slow || !l_q.cmd_s2.stop)
                begin
                    l_d.st        = ccrc_pkg::CCRC_RUN; // RULE4
                    l_d.clkrun_oe = 1'h1;
                end
            end
            default:
            begin
                l_d.st        = ccrc_pkg::CCRC_RUN;
                l_d.clkrun_oe = 1'h1;
            end
        endcase
        l_d.clkrun_o         = 1'h0;
        // Parking lags the reset edge by one link cycle; the card floats meanwhile
        l_d.park_oe          = ~crst_n_out; // RULE7
        l_d.stat.slow        = (l_d.st == ccrc_pkg::CCRC_SLOW);
        l_d.stat.stop        = (l_d.st == ccrc_pkg::CCRC_STOP);
        l_d.stat.card_in_rst = ~crst_n_out;
    end

    always_ff @(posedge link_clk_in or negedge lrst_n)
    begin
        if (!lrst_n)
            l_q <= ccrc_pkg::LINK_RST;
        else
            l_q <= l_d;
    end

    assign cclk_out        = l_q.cclk;
    assign clkrun_out      = l_q.clkrun_o;
    assign clkrun_oe_out   = l_q.clkrun_oe;
    assign park_oe_out     = l_q.park_oe;
    assign sample_stb_out  = l_q.stb;
    // Status bits cross separately; a change may show one cycle of skew between them
    assign slow_out        = h_q.stat_s2.slow;
    assign stopped_out     = h_q.stat_s2.stop;
    assign card_in_rst_out = h_q.stat_s2.card_in_rst;

    sequence s_leave_run;
        l_q.st == ccrc_pkg::CCRC_RUN ##1 l_q.st != ccrc_pkg::CCRC_RUN;
    endsequence

    sequence s_ann_end_req;
        l_q.st == ccrc_pkg::CCRC_ANNOUNCE && l_q.ann_cnt == ANN_LAST && !l_q.clkrun_sync[1];
    endsequence

    AST_STB_ON_RISE: assert property ( // RULE1
        @(posedge link_clk_in) disable iff (!lrst_n)
        sample_stb_out |-> $rose(cclk_out))
        else $error("sample strobe without rising card clock");

    AST_FULL_RATE: assert property ( // RULE2
        @(posedge link_clk_in) disable iff (!lrst_n)
        (l_q.st == ccrc_pkg::CCRC_RUN && $past(l_q.st) == ccrc_pkg::CCRC_RUN && $past(lrst_n))
        |-> cclk_out != $past(cclk_out))
        else $error("card clock not at full rate in run");

    AST_STOP_LOW: assert property ( // RULE3
        @(posedge link_clk_in) disable iff (!lrst_n)
        l_q.st == ccrc_pkg::CCRC_STOP |-> !cclk_out)
        else $error("card clock stopped high");

    AST_WAKE: assert property ( // RULE4
        @(posedge link_clk_in) disable iff (!lrst_n)
        ((l_q.st == ccrc_pkg::CCRC_SLOW || l_q.st == ccrc_pkg::CCRC_STOP) && !l_q.clkrun_sync[1])
        |=> l_q.st == ccrc_pkg::CCRC_RUN && clkrun_oe_out)
        else $error("card clock request not served");

    AST_ANNOUNCE_FIRST: assert property ( // RULE5
        @(posedge link_clk_in) disable iff (!lrst_n)
        s_leave_run |-> l_q.st == ccrc_pkg::CCRC_ANNOUNCE && !clkrun_oe_out)
        else $error("slowdown without announcement");

    AST_ANN_RELEASED: assert property ( // RULE5
        @(posedge link_clk_in) disable iff (!lrst_n)
        l_q.st == ccrc_pkg::CCRC_ANNOUNCE |-> !clkrun_oe_out ##1 (clkrun_oe_out
        || l_q.st != ccrc_pkg::CCRC_RUN))
        else $error("clock-run driven during announcement");

    AST_PARK: assert property ( // RULE7
        @(posedge link_clk_in) disable iff (!lrst_n)
        (!crst_n_out && $past(!crst_n_out)) |-> park_oe_out)
        else $error("interface not parked in card reset");

    AST_RST_RELEASE: assert property ( // RULE9
        @(posedge link_clk_in) disable iff (!lrst_n)
        $rose(crst_n_out) |-> $rose(cclk_out))
        else $error("card reset released off the card clock edge");

    AST_HOLD_ON_REQ: assert property ( // RULE10
        @(posedge link_clk_in) disable iff (!lrst_n)
        s_ann_end_req |=> l_q.st == ccrc_pkg::CCRC_RUN
        ##1 (l_q.st == ccrc_pkg::CCRC_RUN || l_q.st == ccrc_pkg::CCRC_ANNOUNCE))
        else $error("clock slowed while card request pending");

endmodule : ccrc_clock_reset_ctrl

// ==== testbench/ccrc_card_model.sv ====
// Behavioural card in the socket: clock-run requests, outputs floated in reset
`timescale 1ns/1ps
module ccrc_card_model (
    input  wire logic cclk_in,
    input  wire logic crst_n_in,
    input  wire logic bridge_oe_in,
    input  wire logic bridge_val_in,
    input  wire logic req_in,
    output logic      clkrun_pin_out,
    output logic      card_oe_out
);
    logic pull;

    // Not tied to the card clock, so a stopped clock can still be woken
    assign pull = req_in & crst_n_in;
    // Open drain with pull-up: low whenever either party pulls
    assign clkrun_pin_out = ~((bridge_oe_in & ~bridge_val_in) | pull);

    always_ff @(posedge cclk_in or negedge crst_n_in)
    begin
        if (!crst_n_in)
            card_oe_out <= 1'h0;
        else
            card_oe_out <= 1'h1;
    end
endmodule : ccrc_card_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the card clock and reset control
`timescale 1ns/1ps
`define WAITB(c) begin wk = 0; while (!(c) && wk < 500) begin @(posedge link_clk_in); #1; \
    wk++; end if (wk == 500) note(32'h0, 32'h1); end
`define CHK(o, e) if ((o) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, o, e); end
module tb_top;
    logic clk_in          = 1'h0;
    logic link_clk_in     = 1'h0;
    logic rst_n_in        = 1'h0;
    logic slow_req_in     = 1'h0;
    logic stop_req_in     = 1'h0;
    logic card_rst_req_in = 1'h1;
    logic card_req        = 1'h0;
    logic clkrun_in, cclk_out, clkrun_out, clkrun_oe_out, crst_n_out, park_oe_out;
    logic sample_stb_out, slow_out, stopped_out, card_in_rst_out, card_oe;
    logic [31:0] exp_q[$];
    logic [31:0] obs_q[$];
    logic [31:0] xs_s = 32'h3;
    int num_errors = 0;
    int checked    = 0;
    int rises      = 0;
    int wk, n, r0;

    always #5 clk_in = ~clk_in;
    always #3 link_clk_in = ~link_clk_in;
    always @(posedge cclk_out) rises++;

    ccrc_clock_reset_ctrl #(.HALF_SLOW(ccrc_pkg::HALF_SLOW), .ANN_EDGES(ccrc_pkg::ANN_EDGES))
    ccrc_clock_reset_ctrl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .link_clk_in(link_clk_in), .slow_req_in(slow_req_in), .stop_req_in(stop_req_in),
        .card_rst_req_in(card_rst_req_in), .clkrun_in(clkrun_in), .cclk_out(cclk_out),
        .clkrun_out(clkrun_out), .clkrun_oe_out(clkrun_oe_out), .crst_n_out(crst_n_out),
        .park_oe_out(park_oe_out), .sample_stb_out(sample_stb_out), .slow_out(slow_out),
        .stopped_out(stopped_out), .card_in_rst_out(card_in_rst_out));

    ccrc_card_model ccrc_card_model_inst (.cclk_in(cclk_out), .crst_n_in(crst_n_out),
        .bridge_oe_in(clkrun_oe_out), .bridge_val_in(clkrun_out), .req_in(card_req),
        .clkrun_pin_out(clkrun_in), .card_oe_out(card_oe));

    function automatic logic [31:0] xs();
        xs_s = xs_s ^ (xs_s << 13);
        xs_s = xs_s ^ (xs_s >> 17);
        xs_s = xs_s ^ (xs_s << 5);
        return xs_s;
    endfunction : xs

    task note(input logic [31:0] o, input logic [31:0] e);
        exp_q.push_back(e);
        obs_q.push_back(o);
    endtask : note

    // Oldest observation meets oldest expectation
    initial
    begin
        logic [31:0] o, e;
        forever
        begin
            wait (obs_q.size() != 0);
            o = obs_q.pop_front();
            e = exp_q.pop_front();
            checked++;
            `CHK(o, e)
        end
    end

    task half(output int k);
        @(posedge cclk_out);
        k = 0;
        while (cclk_out === 1'h1 && k < 600)
        begin
            @(posedge link_clk_in);
            #1;
            k++;
        end
    endtask : half

    task rel_card;
        @(posedge clk_in);
        card_rst_req_in <= 1'h0;
        `WAITB(crst_n_out === 1'h1)
        note(cclk_out, 1'h1);
        note(sample_stb_out, 1'h1);
        `WAITB(park_oe_out === 1'h0)
        repeat (8) @(posedge clk_in);
        note(card_in_rst_out, 1'h0);
    endtask : rel_card

    task results;
        #1;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    initial
    begin
        #100000;
        num_errors++;
        results();
    end

    initial
    begin
        repeat (2) @(posedge clk_in);
        #1;
        note(crst_n_out, 1'h0);
        note(park_oe_out, 1'h1);
        note(cclk_out, 1'h0);
        note(card_in_rst_out, 1'h1);
        note(card_oe, 1'h0);
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'h1;
        rel_card();
        half(n);
        note(n, ccrc_pkg::HALF_FULL);
        $display("test reset and full rate done");
        @(posedge clk_in);
        slow_req_in <= 1'h1;
        `WAITB(clkrun_oe_out === 1'h0)
        half(n);
        note(n, ccrc_pkg::HALF_FULL);
        repeat (40) @(posedge clk_in);
        half(n);
        note(n, ccrc_pkg::HALF_SLOW);
        note(slow_out, 1'h1);
        $display("test slowdown done");
        card_req <= 1'h1;
        `WAITB(clkrun_oe_out === 1'h1)
        repeat (30) @(posedge clk_in);
        half(n);
        note(n, ccrc_pkg::HALF_FULL);
        note(slow_out, 1'h0);
        card_req <= 1'h0;
        repeat (60) @(posedge clk_in);
        half(n);
        note(n, ccrc_pkg::HALF_SLOW);
        $display("test card request done");
        @(posedge clk_in);
        stop_req_in <= 1'h1;
        repeat (60) @(posedge clk_in);
        note(stopped_out, 1'h1);
        r0 = rises;
        repeat (30) @(posedge clk_in);
        note(rises - r0, 32'h0);
        note(cclk_out, 1'h0);
        card_rst_req_in <= 1'h1;
        `WAITB(crst_n_out === 1'h0)
        `WAITB(park_oe_out === 1'h1)
        note(crst_n_out, 1'h0);
        rel_card();
        repeat (60) @(posedge clk_in);
        note(stopped_out, 1'h1);
        card_req <= 1'h1;
        `WAITB(clkrun_oe_out === 1'h1)
        half(n);
        note(n, ccrc_pkg::HALF_FULL);
        card_req <= 1'h0;
        $display("test stop, wake and card reset done");
        @(posedge clk_in);
        repeat (4)
        begin
            r0 = xs();
            slow_req_in <= r0[0];
            stop_req_in <= r0[1];
            repeat (80) @(posedge clk_in);
            note(stopped_out, r0[1]);
            note(slow_out, r0[0] & ~r0[1]);
        end
        $display("test random modes done");
        results();
    end
endmodule : tb_top
